// ==== hdl/wake_flag_pkg.sv ====
/*
 * Constants for the standby wake event flag block: register offsets,
 * field positions, reset values, source count and power state enum.
 * Assumes a 32-bit AXI4-Lite register bus on a single 100 MHz clock.
 */
// How it works
// RULE_01: enabled sources ORed into one rising-edge detector
// RULE_02: standby entry with flag set exits at once
// RULE_03: writing one to clear bit resets flag
// RULE_04: source held high during clear masks later edges
// RULE_05: software disables, clears, re-enables, then enters standby
// RULE_06: source still high: enter, wake at once, power reset
// RULE_07: clear bit ignores zero, always reads zero
package wake_flag_pkg;
	localparam int NUM_SRC = 4;
	localparam int CLK_HZ = 100_000_000;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
	localparam logic [7:0] OFS_IRQ_CLEAR = 8'h0C;
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h10;
	// ctrl fields
	localparam int CTRL_CLEAR_BIT = 0;
	localparam int CTRL_STANDBY_BIT = 1;
	localparam int CTRL_SRC_EN_LSB = 8;
	// status fields
	localparam int STAT_FLAG_BIT = 0;
	localparam int STAT_STANDBY_BIT = 1;
	localparam int STAT_COMB_BIT = 2;
	localparam int STAT_SRC_LSB = 8;
	// interrupt event bits
	localparam int IRQ_FLAG_SET = 0;
	localparam int IRQ_WAKE = 1;
	localparam int IRQ_W = 2;
	localparam logic [NUM_SRC-1:0] SRC_EN_RESET = 4'h0;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	typedef enum logic [1:0] {PWR_RUN, PWR_STANDBY, PWR_RESET} pwr_state_t;
endpackage

// ==== hdl/wake_edge_detect.sv ====
/*
 * Rising-edge detector on the combined wake level.
 * Assumes the level is synchronous to core_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module wake_edge_detect (
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// level in, edge out
	input wire logic level,
	output logic risePulse
);
	logic prev_reg;

	// prior level held; a level stuck high produces no further edges
	always_ff @(posedge core_clk) begin
		if (sys_rst)
			prev_reg <= 1'b0;
		else
			prev_reg <= level;
	end

	assign risePulse = level & ~prev_reg; // RULE_04
endmodule
`default_nettype wire

// ==== hdl/standby_wakeup_flag_logic.sv ====
/*
 * Standby wake event flag logic with AXI4-Lite registers and interrupt.
 * Assumes wake sources are synchronous to core_clk; powerReset is a
 * one-cycle request consumed by the reset controller outside.
 */
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module standby_wakeup_flag_logic
	import wake_flag_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// wake sources
	input wire logic [NUM_SRC-1:0] wakeSrc,
	// power control
	output logic inStandby,
	output logic powerReset,
	output logic irq,
	// axi4-lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	logic [NUM_SRC-1:0] srcEn_reg;
	logic wake_event_flag_reg;
	logic [IRQ_W-1:0] irqStat_reg;
	logic [IRQ_W-1:0] irqEn_reg;
	pwr_state_t pwr_reg;
	logic powerReset_reg;
	logic [7:0] awAddr_reg;
	logic awHave_reg;
	logic [31:0] wData_reg;
	logic [3:0] wStrb_reg;
	logic wHave_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;

	function automatic logic isMapped(input logic [7:0] a);
		isMapped = (a == OFS_CTRL) || (a == OFS_STATUS) || (a == OFS_IRQ_STATUS)
			|| (a == OFS_IRQ_CLEAR) || (a == OFS_IRQ_ENABLE);
	endfunction

	// write path: address and data latched in either order
	wire doWrite = awHave_reg & wHave_reg & ~bvalid_reg;
	wire wrCtrl = doWrite & (awAddr_reg == OFS_CTRL) & wStrb_reg[0];
	wire wrCtrlHi = doWrite & (awAddr_reg == OFS_CTRL) & wStrb_reg[1];
	wire wrIrqClr = doWrite & (awAddr_reg == OFS_IRQ_CLEAR) & wStrb_reg[0];
	wire wrIrqEn = doWrite & (awAddr_reg == OFS_IRQ_ENABLE) & wStrb_reg[0];
	// a zero in the clear bit does nothing; bit is never stored
	wire wake_event_flag_clear = wrCtrl & wData_reg[CTRL_CLEAR_BIT]; // RULE_07
	wire standbyReq = wrCtrl & wData_reg[CTRL_STANDBY_BIT];

	// combined level and single edge detector
	wire combLevel = |(wakeSrc & srcEn_reg); // RULE_01
	logic edgeSeen;
	wake_edge_detect edgeDet (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.level(combLevel),
		.risePulse(edgeSeen)
	);

	// flag set beats clear so a coincident edge is not lost
	wire flagNext = edgeSeen | (wake_event_flag_reg & ~wake_event_flag_clear); // RULE_01 RULE_03
	// leaving standby: flag already set at entry, or a new edge while in it
	wire wakeNow = (pwr_reg == PWR_STANDBY) & wake_event_flag_reg; // RULE_02 RULE_06
	wire [IRQ_W-1:0] irqEvt = {wakeNow, edgeSeen};

	assign s_axi_awready = ~awHave_reg;
	assign s_axi_wready = ~wHave_reg;
	assign s_axi_arready = ~rvalid_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign inStandby = (pwr_reg == PWR_STANDBY);
	assign powerReset = powerReset_reg;
	assign irq = |(irqStat_reg & irqEn_reg);

	// read mux; clear bit reads zero always
	wire [31:0] ctrlRd = {{(24-NUM_SRC){1'b0}}, srcEn_reg, 8'h00}; // RULE_07
	wire [31:0] statRd = {{(24-NUM_SRC){1'b0}}, wakeSrc, 5'h00, combLevel,
		inStandby, wake_event_flag_reg};
	wire [31:0] rdMux = (s_axi_araddr == OFS_CTRL) ? ctrlRd :
		(s_axi_araddr == OFS_STATUS) ? statRd :
		(s_axi_araddr == OFS_IRQ_STATUS) ? {{(32-IRQ_W){1'b0}}, irqStat_reg} :
		(s_axi_araddr == OFS_IRQ_ENABLE) ? {{(32-IRQ_W){1'b0}}, irqEn_reg} :
		32'h0000_0000;

	// bus channel holding registers
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			awHave_reg <= 1'b0;
			wHave_reg <= 1'b0;
			awAddr_reg <= 8'h00;
			wData_reg <= 32'h0000_0000;
			wStrb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid & ~awHave_reg) begin
				awHave_reg <= 1'b1;
				awAddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid & ~wHave_reg) begin
				wHave_reg <= 1'b1;
				wData_reg <= s_axi_wdata;
				wStrb_reg <= s_axi_wstrb;
			end
			if (doWrite) begin
				awHave_reg <= 1'b0;
				wHave_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg <= isMapped(awAddr_reg) ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_reg & s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// read channel: one cycle after address taken
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= RESP_OKAY;
		end else if (s_axi_arvalid & ~rvalid_reg) begin
			rvalid_reg <= 1'b1;
			rdata_reg <= rdMux;
			rresp_reg <= isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_reg & s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	// source enables and flag
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			srcEn_reg <= SRC_EN_RESET;
			wake_event_flag_reg <= 1'b0;
		end else begin
			if (wrCtrlHi)
				srcEn_reg <= wData_reg[CTRL_SRC_EN_LSB +: NUM_SRC];
			wake_event_flag_reg <= flagNext; // RULE_03
		end
	end

	// interrupt status: set wins over software clear
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			irqStat_reg <= '0;
			irqEn_reg <= '0;
		end else begin
			irqStat_reg <= irqEvt | (irqStat_reg & ~(wrIrqClr ? wData_reg[IRQ_W-1:0] : '0));
			if (wrIrqEn)
				irqEn_reg <= wData_reg[IRQ_W-1:0];
		end
	end

	// power state: entry from run always honoured, even if a wake is pending
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pwr_reg <= PWR_RUN;
			powerReset_reg <= 1'b0;
		end else begin
			powerReset_reg <= 1'b0;
			case (pwr_reg)
				PWR_RUN: begin
					if (standbyReq)
						pwr_reg <= PWR_STANDBY; // RULE_06
				end
				PWR_STANDBY: begin
					if (wakeNow) begin
						pwr_reg <= PWR_RESET;
						powerReset_reg <= 1'b1; // RULE_06
					end
				end
				PWR_RESET: begin
					pwr_reg <= PWR_RUN;
				end
				default: begin
					pwr_reg <= PWR_RUN;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// ==== verif/standby_wakeup_flag_logic_props.sv ====
/* port checker for the wake flag block.
   assumes a bind onto standby_wakeup_flag_logic, one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module standby_wakeup_flag_logic_props (
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// power side
	input wire logic inStandby,
	input wire logic powerReset,
	input wire logic irq,
	// bus answers
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// $fell used so the check survives the disable during reset
	reset_idle_a: assert property ($fell(sys_rst) |-> !inStandby && !powerReset && !s_axi_rvalid)
		else $error("outputs not idle after reset");
	wake_needs_standby_a: assert property (powerReset |-> $past(inStandby))
		else $error("power reset outside standby");
	wake_pulse_once_a: assert property (powerReset |=> !powerReset && !inStandby)
		else $error("power reset not a single pulse");
	standby_exit_a: assert property ($fell(inStandby) |-> powerReset)
		else $error("standby left without power reset");
	read_gate_a: assert property (s_axi_arready != s_axi_rvalid)
		else $error("arready not inverse of rvalid");
	read_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("rvalid kept after handshake");
	write_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("bvalid kept after handshake");
	// main scenarios
	standby_c: cover property ($rose(inStandby));
	wake_c: cover property (powerReset);
	irq_c: cover property ($rose(irq));
endmodule
bind standby_wakeup_flag_logic standby_wakeup_flag_logic_props props (.core_clk(core_clk), .sys_rst(sys_rst),
	.inStandby(inStandby), .powerReset(powerReset), .irq(irq), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready));
`default_nettype wire

// ==== verif/wake_src_model.sv ====
/* wake source model: levels asked by the test, registered.
   assumes core_clk is the block clock. */
`timescale 1ns/1ps
`default_nettype none
module wake_src_model
	import wake_flag_pkg::*;
(
	// clock
	input wire logic core_clk,
	// asked level
	input wire logic [NUM_SRC-1:0] wantLvl,
	// toward the block
	output logic [NUM_SRC-1:0] wakeSrc
);
	// registered so the sources stay synchronous, as the block expects
	always_ff @(posedge core_clk) begin
		wakeSrc <= wantLvl;
	end
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
/* register-level tests of the wake flag block.
   assumes wake_src_model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import wake_flag_pkg::*;
	logic core_clk = 0;
	logic sys_rst = 1;
	logic [NUM_SRC-1:0] wantLvl = '0;
	logic [NUM_SRC-1:0] wakeSrc;
	logic inStandby, powerReset, irq, awready, wready, bvalid, arready, rvalid;
	logic awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
	logic [7:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata, rdV;
	logic [1:0] bresp, rresp, rrV, brV;
	int n_fail = 0, compares = 0, nPr = 0;
	initial forever #5 core_clk = ~core_clk;
	// count wake pulses
	always @(posedge core_clk) if (powerReset === 1'b1) nPr <= nPr + 1;
	wake_src_model src (.core_clk(core_clk), .wantLvl(wantLvl), .wakeSrc(wakeSrc));
	standby_wakeup_flag_logic dut (.core_clk(core_clk), .sys_rst(sys_rst), .wakeSrc(wakeSrc),
		.inStandby(inStandby), .powerReset(powerReset), .irq(irq), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// each channel released at its own handshake
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awv <= 1;
		wv <= 1;
		bready <= 1;
		forever begin
			@(posedge core_clk);
			if (awready) awv <= 0;
			if (wready) wv <= 0;
			if (bvalid) break;
		end
		brV = bresp;
		bready <= 0;
		cyc(1);
	endtask
	task automatic rd(input logic [7:0] a);
		araddr <= a;
		arv <= 1;
		rready <= 1;
		forever begin
			@(posedge core_clk);
			if (arready) arv <= 0;
			if (rvalid) break;
		end
		rdV = rdata;
		rrV = rresp;
		rready <= 0;
		cyc(1);
	endtask
	task automatic chkRd(input string nm, input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(nm, rdV, e);
	endtask
	task automatic tally_and_finish;
		if (n_fail == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// hang guard, far beyond the 125 or so cycles needed
	initial begin
		cyc(3000);
		n_fail++;
		tally_and_finish;
	end
	initial begin
		cyc(20);
		sys_rst <= 0;
		cyc(1);
		chkRd("ctrl", 8'h00, 32'h0000_0000);
		wr(8'h10, 32'h0000_0003);
		chk("wr resp", {30'h0, brV}, {30'h0, RESP_OKAY});
		wr(8'h00, 32'h0000_0500);
		wantLvl <= 4'h4;
		cyc(3);
		chkRd("flag set", 8'h04, 32'h0000_0405);
		chk("irq on", {31'h0, irq}, 32'h0000_0001);
		wr(8'h00, 32'h0000_0501);
		chkRd("clear reads 0", 8'h00, 32'h0000_0500);
		chkRd("flag clr", 8'h04, 32'h0000_0404);
		wantLvl <= 4'h5;
		cyc(3);
		chkRd("masked", 8'h04, 32'h0000_0504);
		// disable, clear, re-enable, enter; sources still high
		wr(8'h00, 32'h0000_0000);
		wr(8'h00, 32'h0000_0001);
		wr(8'h00, 32'h0000_0500);
		wr(8'h00, 32'h0000_0502);
		cyc(2);
		chk("early wake", nPr, 32'h0000_0001);
		chk("run again", {31'h0, inStandby}, 32'h0000_0000);
		chkRd("irq sts", 8'h08, 32'h0000_0003);
		wantLvl <= 4'h0;
		wr(8'h0C, 32'h0000_0003);
		chk("irq clr", {31'h0, irq}, 32'h0000_0000);
		wr(8'h00, 32'h0000_0000);
		wr(8'h00, 32'h0000_0001);
		wr(8'h00, 32'h0000_0500);
		wr(8'h00, 32'h0000_0502);
		cyc(4);
		chk("stays", {nPr[30:0], inStandby}, 32'h0000_0003);
		wantLvl <= 4'h1;
		// source register, edge, flag, pulse, then the counter update
		cyc(6);
		chk("woken", {nPr[30:0], inStandby}, 32'h0000_0004);
		wr(8'h00, 32'h0000_0500);
		chkRd("zero keeps", 8'h04, 32'h0000_0105);
		wr(8'h10, 32'h0000_0000);
		chk("irq mask", {31'h0, irq}, 32'h0000_0000);
		chkRd("unmapped", 8'h20, 32'h0000_0000);
		chk("unmapped resp", {30'h0, rrV}, {30'h0, RESP_SLVERR});
		wr(8'h20, 32'h0000_0001);
		chk("unmapped wr resp", {30'h0, brV}, {30'h0, RESP_SLVERR});
		tally_and_finish;
	end
endmodule
`default_nettype wire
